// ==== ica_pkg.sv ====
package ica_pkg;
    // slot geometry
    localparam int          SLOT_CNT     = 4;
    localparam int          SLOT_W       = 2;
    // register indices, byte address is four times the index
    localparam logic [13:0] PAT_IDX      = 14'h010D;
    localparam logic [13:0] CFG_IDX      = 14'h010E;
    localparam logic [13:0] OFS_IDX      = 14'h010F;
    localparam logic [13:0] SLOT_STRIDE  = 14'h0020;
    localparam logic [13:0] RES1_IDX     = 14'h00F0;
    localparam logic [13:0] RES2_IDX     = 14'h00F1;
    localparam logic [13:0] STAT_IDX     = 14'h00F2;
    // pattern register fields
    localparam int          PAT_W        = 4;
    localparam int          FLIP_LSB     = 0;
    localparam int          NEG_LSB      = 4;
    localparam logic [7:0]  PAT_RST      = 8'h00;
    // slot configuration fields
    localparam int          CNT_LSB      = 0;
    localparam int          CNT_W        = 8;
    localparam int          BIAS_BIT     = 8;
    localparam int          FLOAT_BIT    = 9;
    localparam int          SHIFT_LSB    = 10;
    localparam int          SHIFT_W      = 5;
    localparam logic [15:0] CFG_RST      = 16'h0000;
    // converter offset fields
    localparam int          OFS1_LSB     = 0;
    localparam int          OFS2_LSB     = 16;
    localparam int          OFS_W        = 14;
    localparam logic [31:0] OFS_MASK     = 32'h3FFF_3FFF;
    localparam logic [31:0] OFS_RST      = 32'h0000_0000;
    // status fields
    localparam int          STAT_SLOT_LSB = 8;
    localparam int          STAT_BUSY_BIT = 16;
    // datapath
    localparam int          CONV_W       = 14;
    localparam int          ACC_W        = 32;
    localparam logic [31:0] MIDSCALE_BIAS = 32'h0000_0800;
    // bus answers
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage

// ==== ica_chan_acc.sv ====
`timescale 1ns/1ps
// one converter channel: signed pulse summing, shift and bias
module ica_chan_acc (
    input  wire logic                                clk_i,
    input  wire logic                                rst_n_i,
    input  wire logic                                clear_i,
    input  wire logic                                add_i,
    input  wire logic                                negate_i,
    input  wire logic [ica_pkg::CONV_W-1:0]          conv_i,
    input  wire logic [ica_pkg::OFS_W-1:0]           offset_i,
    input  wire logic                                finish_i,
    input  wire logic                                bias_en_i,
    input  wire logic [ica_pkg::SHIFT_W-1:0]         shift_i,
    output logic      [ica_pkg::ACC_W-1:0]           result_o
);
    logic signed [ica_pkg::ACC_W-1:0] acc_ff;
    logic signed [ica_pkg::ACC_W-1:0] nxt_acc;
    logic        [ica_pkg::ACC_W-1:0] result_ff;
    logic        [ica_pkg::ACC_W-1:0] nxt_result;
    logic signed [ica_pkg::ACC_W-1:0] term;
    logic signed [ica_pkg::ACC_W-1:0] shifted;

    // per-pulse term: unsigned code plus signed offset
    assign term = $signed({{(ica_pkg::ACC_W-ica_pkg::CONV_W){1'b0}}, conv_i})
                + $signed({{(ica_pkg::ACC_W-ica_pkg::OFS_W){offset_i[ica_pkg::OFS_W-1]}}, offset_i});
    assign shifted = acc_ff >>> shift_i; // keeps the upper bits, sign preserved

    // accumulate, clear wins since a new sample starts from zero
    always_comb begin
        nxt_acc    = acc_ff;
        nxt_result = result_ff;
        if (clear_i) begin
            nxt_acc = '0;
        end else if (add_i) begin
            nxt_acc = negate_i ? acc_ff - term : acc_ff + term;
        end
        if (finish_i) begin
            // bias after the shift so it stays 2048 codes at the output
            nxt_result = bias_en_i ? 32'(shifted) + ica_pkg::MIDSCALE_BIAS : 32'(shifted);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            acc_ff    <= '0;
            result_ff <= '0;
        end else begin
            acc_ff    <= nxt_acc;
            result_ff <= nxt_result;
        end
    end

    assign result_o = result_ff;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_clear_to_zero: assert property (clear_i |=> acc_ff == 0)
        else $error("accumulator not cleared at sample start");
    a_negate_subtracts: assert property (add_i && !clear_i && negate_i |=> acc_ff == $past(acc_ff) - $past(term))
        else $error("negated pulse not subtracted");
    a_bias_added: assert property (finish_i && bias_en_i
        |=> result_o == 32'($past(acc_ff) >>> $past(shift_i)) + 32'h0000_0800)
        else $error("midscale bias not added");
    a_shift_applied: assert property (finish_i && !bias_en_i && shift_i == 5'h01
        |=> result_o == 32'($past(acc_ff) >>> 1))
        else $error("result shift wrong");
endmodule

// ==== ica_chop_acc.sv ====
`timescale 1ns/1ps
// Functional notes
// - negate pattern bits subtract matching pulse positions
// - reverse pattern swaps integrator phase per position
// - both patterns repeat every four pulses
// - negate-marked pulses subtracted, others added, whatever the reverse bit
// - pattern 0xA flips and subtracts pulses two, four
// - bias enable adds 2048 codes to result
// - pattern at 0x010D, next slot plus 0x020
// - float mode bypasses the bandpass filter stage
// - float mode integrates charge in negative phase
// - output sums converter results over repeat count
// - accumulated value right-shifted before output
module ica_chop_acc (
    input  wire logic                          clk_i,
    input  wire logic                          rst_n_i,
    input  wire logic [15:0]                   s_axi_awaddr_i,
    input  wire logic                          s_axi_awvalid_i,
    output logic                               s_axi_awready_o,
    input  wire logic [31:0]                   s_axi_wdata_i,
    input  wire logic [3:0]                    s_axi_wstrb_i,
    input  wire logic                          s_axi_wvalid_i,
    output logic                               s_axi_wready_o,
    output logic [1:0]                         s_axi_bresp_o,
    output logic                               s_axi_bvalid_o,
    input  wire logic                          s_axi_bready_i,
    input  wire logic [15:0]                   s_axi_araddr_i,
    input  wire logic                          s_axi_arvalid_i,
    output logic                               s_axi_arready_o,
    output logic [31:0]                        s_axi_rdata_o,
    output logic [1:0]                         s_axi_rresp_o,
    output logic                               s_axi_rvalid_o,
    input  wire logic                          s_axi_rready_i,
    input  wire logic                          sample_start_i,
    input  wire logic [ica_pkg::SLOT_W-1:0]    sample_slot_i,
    input  wire logic                          conv_valid_i,
    input  wire logic [ica_pkg::CONV_W-1:0]    conv_ch1_i,
    input  wire logic [ica_pkg::CONV_W-1:0]    conv_ch2_i,
    output logic                               integ_phase_flip_o,
    output logic                               bpf_bypass_o,
    output logic                               float_neg_capture_o,
    output logic                               busy_o,
    output logic                               result_valid_o,
    output logic [ica_pkg::SLOT_W-1:0]         result_slot_o,
    output logic [ica_pkg::ACC_W-1:0]          result_ch1_o,
    output logic [ica_pkg::ACC_W-1:0]          result_ch2_o
);
    typedef enum logic [1:0] {ICA_IDLE, ICA_ACCUM, ICA_FINISH} ica_state_t;

    // register file
    logic [7:0]                     pat_ff [ica_pkg::SLOT_CNT];
    logic [7:0]                     nxt_pat [ica_pkg::SLOT_CNT];
    logic [15:0]                    cfg_ff [ica_pkg::SLOT_CNT];
    logic [15:0]                    nxt_cfg [ica_pkg::SLOT_CNT];
    logic [31:0]                    ofs_ff [ica_pkg::SLOT_CNT];
    logic [31:0]                    nxt_ofs [ica_pkg::SLOT_CNT];
    // bus handshake
    logic                           awready_ff, nxt_awready;
    logic                           wready_ff, nxt_wready;
    logic                           bvalid_ff, nxt_bvalid;
    logic [1:0]                     bresp_ff, nxt_bresp;
    logic                           arready_ff, nxt_arready;
    logic                           rvalid_ff, nxt_rvalid;
    logic [1:0]                     rresp_ff, nxt_rresp;
    logic [31:0]                    rdata_ff, nxt_rdata;
    logic                           wr_fire, rd_fire;
    logic [13:0]                    wr_idx, rd_idx;
    // sequencer
    ica_state_t                     state_ff, nxt_state;
    logic [ica_pkg::SLOT_W-1:0]     slot_ff, nxt_slot;
    logic [1:0]                     pos_ff, nxt_pos;
    logic [ica_pkg::CNT_W-1:0]      taken_ff, nxt_taken;
    logic                           flip_ff, nxt_flip;
    logic                           bypass_ff, nxt_bypass;
    logic                           done_ff, nxt_done, busy_ff, nxt_busy;
    logic                           start_ok, take, last;
    logic [ica_pkg::CNT_W-1:0]      count;
    logic                           negate;
    logic [15:0]                    cur_cfg;
    logic [31:0]                    cur_ofs;

    assign wr_fire = awready_ff && s_axi_awvalid_i && s_axi_wvalid_i;
    assign rd_fire = arready_ff && s_axi_arvalid_i;
    assign wr_idx  = s_axi_awaddr_i[15:2];
    assign rd_idx  = s_axi_araddr_i[15:2];

    // merge written byte lanes into an old value
    function automatic logic [31:0] ica_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return res;
    endfunction

    // write channel: address and data taken together, answer after both
    always_comb begin
        logic hit;
        hit         = 1'b0;
        nxt_pat     = pat_ff;
        nxt_cfg     = cfg_ff;
        nxt_ofs     = ofs_ff;
        nxt_awready = !awready_ff && !bvalid_ff && s_axi_awvalid_i && s_axi_wvalid_i;
        nxt_wready  = nxt_awready;
        nxt_bvalid  = bvalid_ff && !s_axi_bready_i;
        nxt_bresp   = bresp_ff;
        if (wr_fire) begin
            for (int s = 0; s < ica_pkg::SLOT_CNT; s++) begin
                if (wr_idx == ica_pkg::PAT_IDX + 14'(ica_pkg::SLOT_STRIDE * s)) begin
                    nxt_pat[s] = 8'(ica_merge({24'h0, pat_ff[s]}, s_axi_wdata_i, s_axi_wstrb_i));
                    hit        = 1'b1;
                end
                if (wr_idx == ica_pkg::CFG_IDX + 14'(ica_pkg::SLOT_STRIDE * s)) begin
                    nxt_cfg[s] = 16'(ica_merge({16'h0, cfg_ff[s]}, s_axi_wdata_i, s_axi_wstrb_i));
                    hit        = 1'b1;
                end
                if (wr_idx == ica_pkg::OFS_IDX + 14'(ica_pkg::SLOT_STRIDE * s)) begin
                    nxt_ofs[s] = ica_merge(ofs_ff[s], s_axi_wdata_i, s_axi_wstrb_i) & ica_pkg::OFS_MASK;
                    hit        = 1'b1;
                end
            end
            nxt_bvalid = 1'b1;
            nxt_bresp  = hit ? ica_pkg::RESP_OKAY : ica_pkg::RESP_SLVERR;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            for (int s = 0; s < ica_pkg::SLOT_CNT; s++) begin
                pat_ff[s] <= ica_pkg::PAT_RST;
                cfg_ff[s] <= ica_pkg::CFG_RST;
                ofs_ff[s] <= ica_pkg::OFS_RST;
            end
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= ica_pkg::RESP_OKAY;
        end else begin
            pat_ff     <= nxt_pat;
            cfg_ff     <= nxt_cfg;
            ofs_ff     <= nxt_ofs;
            awready_ff <= nxt_awready;
            wready_ff  <= nxt_wready;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
        end
    end

    // read channel: one cycle of arready, data one edge later
    always_comb begin
        logic hit;
        hit         = 1'b0;
        nxt_arready = !arready_ff && !rvalid_ff && s_axi_arvalid_i;
        nxt_rvalid  = rvalid_ff && !s_axi_rready_i;
        nxt_rdata   = rdata_ff;
        nxt_rresp   = rresp_ff;
        if (rd_fire) begin
            nxt_rdata = 32'h0000_0000;
            for (int s = 0; s < ica_pkg::SLOT_CNT; s++) begin
                if (rd_idx == ica_pkg::PAT_IDX + 14'(ica_pkg::SLOT_STRIDE * s)) begin
                    nxt_rdata = {24'h0, pat_ff[s]};
                    hit       = 1'b1;
                end
                if (rd_idx == ica_pkg::CFG_IDX + 14'(ica_pkg::SLOT_STRIDE * s)) begin
                    nxt_rdata = {16'h0, cfg_ff[s]};
                    hit       = 1'b1;
                end
                if (rd_idx == ica_pkg::OFS_IDX + 14'(ica_pkg::SLOT_STRIDE * s)) begin
                    nxt_rdata = ofs_ff[s];
                    hit       = 1'b1;
                end
            end
            if (rd_idx == ica_pkg::RES1_IDX) begin
                nxt_rdata = result_ch1_o;
                hit       = 1'b1;
            end
            if (rd_idx == ica_pkg::RES2_IDX) begin
                nxt_rdata = result_ch2_o;
                hit       = 1'b1;
            end
            if (rd_idx == ica_pkg::STAT_IDX) begin
                nxt_rdata = 32'h0000_0000;
                nxt_rdata[ica_pkg::CNT_W-1:0]                              = taken_ff;
                nxt_rdata[ica_pkg::STAT_SLOT_LSB +: ica_pkg::SLOT_W]       = slot_ff;
                nxt_rdata[ica_pkg::STAT_BUSY_BIT]                          = state_ff != ICA_IDLE;
                hit       = 1'b1;
            end
            nxt_rvalid = 1'b1;
            nxt_rresp  = hit ? ica_pkg::RESP_OKAY : ica_pkg::RESP_SLVERR;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= ica_pkg::RESP_OKAY;
        end else begin
            arready_ff <= nxt_arready;
            rvalid_ff  <= nxt_rvalid;
            rdata_ff   <= nxt_rdata;
            rresp_ff   <= nxt_rresp;
        end
    end

    // active slot settings; config is read live, so rewrite it only between samples
    assign cur_cfg  = cfg_ff[slot_ff];
    assign cur_ofs  = ofs_ff[slot_ff];
    assign count    = cur_cfg[ica_pkg::CNT_LSB +: ica_pkg::CNT_W];
    assign start_ok = sample_start_i && state_ff == ICA_IDLE;
    assign take     = conv_valid_i && state_ff == ICA_ACCUM;
    assign last     = 8'(taken_ff + 8'h01) == count;
    assign negate   = pat_ff[slot_ff][ica_pkg::NEG_LSB + 32'(pos_ff)];

    // pulse sequencer
    always_comb begin
        logic [15:0] ncfg;
        ncfg      = cfg_ff[slot_ff];
        nxt_state = state_ff;
        nxt_slot  = slot_ff;
        nxt_pos   = pos_ff;
        nxt_taken = taken_ff;
        nxt_done  = 1'b0;
        unique case (state_ff)
            ICA_IDLE: begin
                if (sample_start_i) begin
                    nxt_slot  = sample_slot_i;
                    nxt_pos   = 2'h0;
                    nxt_taken = 8'h00;
                    ncfg      = cfg_ff[sample_slot_i];
                    // zero pulses still gives a (bias only) result
                    nxt_state = (ncfg[ica_pkg::CNT_LSB +: ica_pkg::CNT_W] == 8'h00) ? ICA_FINISH : ICA_ACCUM;
                end
            end
            ICA_ACCUM: begin
                if (take) begin
                    nxt_pos   = 2'(pos_ff + 2'h1);
                    nxt_taken = 8'(taken_ff + 8'h01);
                    if (last) begin
                        nxt_state = ICA_FINISH;
                    end
                end
            end
            ICA_FINISH: begin
                nxt_done  = 1'b1;
                nxt_state = ICA_IDLE;
            end
            default: nxt_state = ICA_IDLE;
        endcase
        ncfg       = cfg_ff[nxt_slot];
        // flip bit follows the pulse about to be integrated
        nxt_flip   = (nxt_state == ICA_ACCUM) && pat_ff[nxt_slot][ica_pkg::FLIP_LSB + 32'(nxt_pos)];
        nxt_bypass = ncfg[ica_pkg::FLOAT_BIT];
        nxt_busy   = nxt_state != ICA_IDLE; // registered so the pin has no decode glitch
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_ff  <= ICA_IDLE;
            slot_ff   <= '0;
            pos_ff    <= 2'h0;
            taken_ff  <= 8'h00;
            flip_ff   <= 1'b0;
            bypass_ff <= 1'b0;
            done_ff   <= 1'b0;
            busy_ff   <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            slot_ff   <= nxt_slot;
            pos_ff    <= nxt_pos;
            taken_ff  <= nxt_taken;
            flip_ff   <= nxt_flip;
            bypass_ff <= nxt_bypass;
            done_ff   <= nxt_done;
            busy_ff   <= nxt_busy;
        end
    end

    // two identical channels share the sequencing
    ica_chan_acc u_ch1 (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .clear_i   (start_ok),
        .add_i     (take),
        .negate_i  (negate),
        .conv_i    (conv_ch1_i),
        .offset_i  (cur_ofs[ica_pkg::OFS1_LSB +: ica_pkg::OFS_W]),
        .finish_i  (state_ff == ICA_FINISH),
        .bias_en_i (cur_cfg[ica_pkg::BIAS_BIT]),
        .shift_i   (cur_cfg[ica_pkg::SHIFT_LSB +: ica_pkg::SHIFT_W]),
        .result_o  (result_ch1_o)
    );
    ica_chan_acc u_ch2 (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .clear_i   (start_ok),
        .add_i     (take),
        .negate_i  (negate),
        .conv_i    (conv_ch2_i),
        .offset_i  (cur_ofs[ica_pkg::OFS2_LSB +: ica_pkg::OFS_W]),
        .finish_i  (state_ff == ICA_FINISH),
        .bias_en_i (cur_cfg[ica_pkg::BIAS_BIT]),
        .shift_i   (cur_cfg[ica_pkg::SHIFT_LSB +: ica_pkg::SHIFT_W]),
        .result_o  (result_ch2_o)
    );

    // outputs straight from flops
    assign s_axi_awready_o     = awready_ff;
    assign s_axi_wready_o      = wready_ff;
    assign s_axi_bvalid_o      = bvalid_ff;
    assign s_axi_bresp_o       = bresp_ff;
    assign s_axi_arready_o     = arready_ff;
    assign s_axi_rvalid_o      = rvalid_ff;
    assign s_axi_rresp_o       = rresp_ff;
    assign s_axi_rdata_o       = rdata_ff;
    assign integ_phase_flip_o  = flip_ff;
    assign bpf_bypass_o        = bypass_ff;
    assign float_neg_capture_o = bypass_ff;
    assign busy_o              = busy_ff;
    assign result_valid_o      = done_ff;
    assign result_slot_o       = slot_ff;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_start_taken;
        start_ok && cfg_ff[sample_slot_i][7:0] != 8'h00;
    endsequence
    sequence s_first_pulse;
        state_ff == ICA_ACCUM && pos_ff == 2'h0 && taken_ff == 8'h00;
    endsequence

    a_start_restarts: assert property (s_start_taken |=> s_first_pulse)
        else $error("pulse position not restarted");
    a_flip_follows_pos: assert property (state_ff == ICA_ACCUM |-> flip_ff == pat_ff[slot_ff][pos_ff])
        else $error("phase flip does not match pattern");
    a_position_wraps: assert property (take && !last |=> pos_ff == 2'($past(pos_ff) + 2'h1))
        else $error("pulse position not cyclic");
    a_negate_from_pattern: assert property (take |-> negate == pat_ff[slot_ff][4 + 32'(pos_ff)])
        else $error("negate bit not from pattern");
    a_alt_pattern: assert property (take && pat_ff[slot_ff] == 8'hAA && pos_ff[0] |-> negate && flip_ff)
        else $error("pattern 0xA not applied to even pulses");
    a_done_after_count: assert property (take && last |=> ##1 result_valid_o && taken_ff == cur_cfg[7:0])
        else $error("result not after programmed pulse count");
    a_float_bypass: assert property (state_ff != ICA_IDLE |-> bpf_bypass_o == cur_cfg[9]
        && float_neg_capture_o == bpf_bypass_o)
        else $error("float mode bypass wrong");
    a_slot_pattern_write: assert property (wr_fire && wr_idx == 14'h012D && s_axi_wstrb_i[0]
        |=> pat_ff[1] == $past(s_axi_wdata_i[7:0]))
        else $error("second slot pattern not at its address");
endmodule

// ==== ica_conv_model.sv ====
`timescale 1ns/1ps
// converter model: one result a cycle once started, ramping values per pulse
module ica_conv_model (
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  go_i,
    input  wire logic [7:0]            count_i,
    output logic                       conv_valid_o,
    output logic [ica_pkg::CONV_W-1:0] ch1_o,
    output logic [ica_pkg::CONV_W-1:0] ch2_o
);
    logic [7:0] k_ff;
    // idle lines invert their value every cycle so stale data cannot pass
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            conv_valid_o <= 1'b0;
            k_ff <= 8'h00;
            ch1_o <= 14'h0000;
            ch2_o <= 14'h0000;
        end else if (go_i && count_i != 8'h00) begin
            conv_valid_o <= 1'b1;
            k_ff <= 8'h01;
            ch1_o <= 14'h0100;
            ch2_o <= 14'h0040;
        end else if (conv_valid_o && k_ff < count_i) begin
            k_ff <= k_ff + 8'h01;
            ch1_o <= 14'h0100 + 14'(k_ff) * 14'h0010;
            ch2_o <= 14'h0040 + 14'(k_ff);
        end else begin
            conv_valid_o <= 1'b0;
            ch1_o <= ~ch1_o;
            ch2_o <= ~ch2_o;
        end
    end
endmodule

// ==== tb_ica_chop_acc.sv ====
`timescale 1ns/1ps
module tb_ica_chop_acc;
    logic clk_i = 1'b0, rst_n_i = 1'b0, s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, sample_start_i = 1'b0, conv_valid_i;
    logic [15:0] s_axi_awaddr_i = 16'h0000, s_axi_araddr_i = 16'h0000;
    logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, result_ch1_o, result_ch2_o, d;
    logic [3:0] s_axi_wstrb_i = 4'hF, cur_pat = 4'h0;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, sample_slot_i = 2'h0, result_slot_o;
    logic [13:0] conv_ch1_i, conv_ch2_i;
    logic [7:0] cnt = 8'h00;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic integ_phase_flip_o, bpf_bypass_o, float_neg_capture_o, busy_o, result_valid_o;
    int n_errors = 0, num_checks = 0, pk = 0, cyc = 0;
    ica_chop_acc DUT (.clk_i, .rst_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
        .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
        .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
        .s_axi_rready_i, .sample_start_i, .sample_slot_i, .conv_valid_i, .conv_ch1_i, .conv_ch2_i,
        .integ_phase_flip_o, .bpf_bypass_o, .float_neg_capture_o, .busy_o, .result_valid_o, .result_slot_o,
        .result_ch1_o, .result_ch2_o);
    ica_conv_model conv (.clk_i, .rst_n_i, .go_i(sample_start_i), .count_i(cnt), .conv_valid_o(conv_valid_i),
        .ch1_o(conv_ch1_i), .ch2_o(conv_ch2_i));
    always #10 clk_i = ~clk_i;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // write and read hold valids until their ready edge, ready lines until the answer
    task automatic wr(input logic [13:0] idx, input logic [31:0] v, input logic [1:0] er);
        @(posedge clk_i);
        s_axi_awaddr_i <= {idx, 2'b00};
        s_axi_wdata_i <= v;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        @(posedge clk_i);
        while (s_axi_awready_o !== 1'b1 || s_axi_wready_o !== 1'b1) @(posedge clk_i);
        s_axi_awvalid_i <= 1'b0;
        s_axi_wvalid_i <= 1'b0;
        while (s_axi_bvalid_o !== 1'b1) @(posedge clk_i);
        chk(32'(s_axi_bresp_o), 32'(er));
        s_axi_bready_i <= 1'b0;
    endtask
    task automatic rd(input logic [13:0] idx, output logic [31:0] v, input logic [1:0] er);
        @(posedge clk_i);
        s_axi_araddr_i <= {idx, 2'b00};
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        @(posedge clk_i);
        while (s_axi_arready_o !== 1'b1) @(posedge clk_i);
        s_axi_arvalid_i <= 1'b0;
        while (s_axi_rvalid_o !== 1'b1) @(posedge clk_i);
        v = s_axi_rdata_o;
        chk(32'(s_axi_rresp_o), 32'(er));
        s_axi_rready_i <= 1'b0;
    endtask
    function automatic logic [31:0] ex(input logic [3:0] ng, input int n, sh, input logic b, input int a, st);
        int s;
        s = 0;
        for (int k = 0; k < n; k++) s += ng[k % 4] ? -(a + st * k) : (a + st * k);
        s = s >>> sh;
        return 32'(s) + (b ? ica_pkg::MIDSCALE_BIAS : 32'h0);
    endfunction
    task automatic smp(input logic [1:0] s, input logic [7:0] pat, n, input int sh, input logic b, fl);
        logic [13:0] o;
        o = 14'(s) * ica_pkg::SLOT_STRIDE;
        wr(ica_pkg::PAT_IDX + o, 32'(pat), ica_pkg::RESP_OKAY);
        wr(ica_pkg::CFG_IDX + o, 32'(n) | 32'(b) << 8 | 32'(fl) << 9 | 32'(sh) << 10, ica_pkg::RESP_OKAY);
        wr(ica_pkg::OFS_IDX + o, 32'h0, ica_pkg::RESP_OKAY);
        cur_pat = pat[3:0];
        pk = 0;
        @(posedge clk_i);
        sample_slot_i <= s;
        cnt <= n;
        sample_start_i <= 1'b1;
        @(posedge clk_i);
        sample_start_i <= 1'b0;
        @(posedge clk_i);
        chk(32'(bpf_bypass_o), 32'(fl));
        chk(32'(float_neg_capture_o), 32'(fl));
        chk(32'(busy_o), 32'h1);
        while (result_valid_o !== 1'b1) @(posedge clk_i);
        chk(result_ch1_o, ex(pat[7:4], n, sh, b, 256, 16));
        chk(result_ch2_o, ex(pat[7:4], n, sh, b, 64, 1));
        chk(32'(result_slot_o), 32'(s));
        chk(32'(pk), 32'(n));
        chk(32'(busy_o), 32'h0);
        $display("sample test slot %0d done", s);
    endtask
    // phase flip must follow the pattern bit of each presented pulse
    always @(posedge clk_i) begin
        if (conv_valid_i === 1'b1 && busy_o === 1'b1) begin
            chk(32'(integ_phase_flip_o), 32'(cur_pat[pk % 4]));
            pk++;
        end
    end
    // hang guard, the whole run needs well under a thousand cycles
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            give_verdict;
        end
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(ica_pkg::PAT_IDX, d, ica_pkg::RESP_OKAY);
        chk(d, 32'(ica_pkg::PAT_RST));
        rd(ica_pkg::CFG_IDX, d, ica_pkg::RESP_OKAY);
        chk(d, 32'(ica_pkg::CFG_RST));
        rd(ica_pkg::OFS_IDX, d, ica_pkg::RESP_OKAY);
        chk(d, ica_pkg::OFS_RST);
        wr(ica_pkg::PAT_IDX + 14'h0060, 32'h0000_12AA, ica_pkg::RESP_OKAY);
        rd(ica_pkg::PAT_IDX + 14'h0060, d, ica_pkg::RESP_OKAY);
        chk(d, 32'h0000_00AA);
        rd(14'h0000, d, ica_pkg::RESP_SLVERR);
        chk(d, 32'h0);
        wr(ica_pkg::RES1_IDX, 32'h1, ica_pkg::RESP_SLVERR);
        $display("register test done");
        smp(2'h1, 8'hAA, 8'h08, 0, 1'b1, 1'b0);
        smp(2'h2, 8'h5C, 8'h06, 1, 1'b0, 1'b1);
        rd(ica_pkg::RES1_IDX, d, ica_pkg::RESP_OKAY);
        chk(d, 32'h0000_0018);
        rd(ica_pkg::RES2_IDX, d, ica_pkg::RESP_OKAY);
        chk(d, 32'h0000_0001);
        rd(ica_pkg::STAT_IDX, d, ica_pkg::RESP_OKAY);
        chk(d, 32'h0000_0206);
        $display("readback test done");
        // zero pulses: result is the midscale bias alone
        smp(2'h0, 8'h00, 8'h00, 0, 1'b1, 1'b0);
        give_verdict;
    end
endmodule
